// ### src/cec_consts.svh
// Purpose: Offsets, bit positions, reset values and counts for the
//          crypto engine controller registers.
// Assumes: Bit positions are LSB-numbered (bit 0 = least significant).
// Notes:   Included by the package; definitions only.
`ifndef CEC_CONSTS_SVH
`define CEC_CONSTS_SVH

// Register byte offsets on the plain register port
`define CEC_ADDR_W 18
`define CEC_OFS_IEN 18'h31008
`define CEC_OFS_IST 18'h31010
`define CEC_OFS_ICLR 18'h31018
`define CEC_OFS_UASG 18'h31028
`define CEC_OFS_MCTL 18'h31030

// Reset values
`define CEC_IEN_RST 64'h0000_0000_0000_0000
`define CEC_MCTL_RST 32'h0000_0000

// Interrupt bit positions
`define CEC_BIT_FETCH_WRAP 55
`define CEC_BIT_DESC_WRAP 54
`define CEC_BIT_DIN_WRAP 53
`define CEC_BIT_DOUT_WRAP 52
`define CEC_BIT_ITO 48
`define CEC_BIT_OVF_BASE 40
`define CEC_BIT_CH_DN_BASE 32
// Done bit of units 0..7, five bits each, unit 0 lowest; error is done+1
`define CEC_UNIT_DN_POS {5'd0, 5'd4, 5'd8, 5'd12, 5'd16, 5'd20, 5'd24, 5'd26}
// Implemented bits; all others read zero
`define CEC_IRQ_MASK 64'h00f1_0fff_0f33_3333
`define CEC_DONE_MASK 64'h0000_0055_0000_0000

// Master control bit positions
`define CEC_MC_SNOOP 33
`define CEC_MC_SRST 32

// Unit assignment codes
`define CEC_ASG_FREE 4'h0
`define CEC_ASG_UNAVAIL 4'hf

// Counts
`define CEC_TIMEOUT_CYC 5'd16
`define CEC_QUEUE_MAX 4'hf
`define CEC_SRST_CYC 4'h8
`define CEC_PRIO_ZERO_AS 9'h100

`endif

// ### src/cec_pkg.sv
// Purpose: Types shared by the crypto engine controller registers.
// Assumes: cec_consts.svh gives the widths.
// Notes:   All state of the controller is one packed struct.
`include "cec_consts.svh"

package cec_pkg;

	// Register port request from host software
	typedef struct packed {
		logic wr;
		logic rd;
		logic [`CEC_ADDR_W-1:0] addr;
		logic [63:0] wdata;
	} cec_bus_t;

	// Counter rollover pulses from the fetch and data counters
	typedef struct packed {
		logic fetch_enqueue_wrap;
		logic descriptor_finished_wrap;
		logic data_in_wrap;
		logic data_out_wrap;
	} cec_wrap_t;

	// Unit reservation or release by a channel (chan 0..3 = ch1..ch4)
	typedef struct packed {
		logic valid;
		logic release_unit;
		logic [1:0] chan;
		logic [2:0] unit;
	} cec_rsv_t;

	// Internal slave access in flight towards a channel or unit
	typedef struct packed {
		logic busy;
		logic ack;
	} cec_slv_t;

	typedef struct packed {
		logic [63:0] en;
		logic [63:0] st;
		logic [63:0] pend;
		logic [3:0][3:0] dq;
		logic [7:0][3:0] asg;
		logic snoop;
		logic [31:0] prio;
		logic srst;
		logic [3:0] srst_cnt;
		logic [4:0] to_cnt;
		logic to_abort;
		logic [1:0][1:0] last;
		logic [1:0][1:0][8:0] deny;
		logic [1:0][3:0] grant;
		logic rsv_ok;
		logic rsv_refused;
		logic irq;
		logic [63:0] rdata;
	} cec_state_t;

endpackage

// ### src/cec_ctrl.sv
// Purpose: Controller registers of the crypto engine: unit assignment,
//          interrupt enable/status/clear, done queues, master control
//          and the two weighted/round-robin channel arbiters.
// Assumes: All event inputs come from logic on i_core_clk.
// Notes:   Notes on behaviour below.
// Register map, byte offsets on the plain register port:
//   interrupt_enable        read-write, reset all zero
//   interrupt_status        read-only, writes are ignored
//   interrupt_clear         write-only, reads return zero
//   unit_assignment_status  read-only, eight four-bit fields
//   master_control          snoop, soft reset and four counts
// Any other offset reads zero and ignores writes.
//
// Bit numbering:
//   All registers use LSB numbering inside this block, so a bit
//   that software lists as position b sits at our index 63 - b.
//   The header of constants holds every position already flipped.
//
// Read timing:
//   A read strobe is taken at one rising edge and its data stand on
//   o_rdata for exactly the following cycle; outside that slot the
//   port reads zero, which keeps a monitor from seeing stale words.
//   The slave never inserts wait states.
//
// Interrupt timing:
//   A cause taken at edge n sets its status bit at edge n and the
//   host interrupt at the same edge. A clear written at edge n drops
//   the bit at that same edge n. Enable is looked at as registered, so a
//   cause in the same cycle as the enable write is dropped.
//
// Clear against a live cause:
//   The clear wins for one cycle and the bit returns in the next,
//   so software sees the clear take effect yet no event is lost.
//   Channel done bits do the same through their queue counters.
//
// Done queues:
//   Each channel counts up to fifteen extra done events. A further
//   event while the counter is full raises the overflow bit of that
//   channel and is otherwise lost; software must drain faster.
//
// Unit assignment:
//   A reservation answers with one pulse, ok or refused, in the
//   cycle after the request. A release by a channel that does not
//   own the unit is ignored without any answer, so a faulty channel
//   cannot free a unit held by another one.
//
// Arbiters:
//   Both arbiters decide every cycle and show a one-hot grant for
//   one cycle. A denial counter stops once its channel is promoted
//   and restarts from zero when that channel wins; the counters are
//   nine bits wide so that a zero count can stand for 256.
//
// Soft reset:
//   Writing the reset bit holds o_soft_reset high for nine cycles.
//   Status, queues, table and arbiters are wiped meanwhile; enable
//   and master control settings survive so that software need not
//   program them again.
//
// Internal watchdog:
//   An internal access left unanswered for sixteen edges is closed
//   by a one-cycle abort pulse; the counter then starts again, so a
//   slave that stays silent is aborted once every sixteen cycles.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/10ps

module cec_ctrl
	import cec_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rstn,
	input wire cec_bus_t i_bus,
	output logic [63:0] o_rdata,
	input wire cec_wrap_t i_wrap,
	input wire logic [3:0] i_ch_done,
	input wire logic [3:0] i_ch_err,
	input wire logic [7:0] i_unit_done,
	input wire logic [7:0] i_unit_err,
	input wire logic [7:0] i_unit_unavail,
	input wire cec_rsv_t i_rsv,
	output logic o_rsv_ok,
	output logic o_rsv_refused,
	input wire cec_slv_t i_slv,
	output logic o_slv_abort,
	input wire logic [1:0][3:0] i_arb_req,
	output logic [1:0][3:0] o_arb_grant,
	output logic o_snoop_inhibit,
	output logic o_soft_reset,
	output logic o_irq
);

	cec_state_t s_reg;
	cec_state_t s_next;

	// Next-state logic for the whole controller
	always_comb begin
		logic [63:0] clr;
		logic [63:0] cause;
		logic [63:0] gen;
		logic [63:0] dn_st;
		logic [4:0] pos;
		logic [3:0] cnt;
		logic [3:0] g;
		logic [7:0] c3;
		logic [7:0] c4;
		logic [8:0] lim3;
		logic [8:0] lim4;
		logic [1:0] idx;
		logic cur;
		logic cl;
		logic found;
		logic el3;
		logic el4;
		clr = '0;
		cause = '0;
		gen = '0;
		dn_st = '0;
		pos = '0;
		cnt = '0;
		g = '0;
		c3 = '0;
		c4 = '0;
		lim3 = '0;
		lim4 = '0;
		idx = '0;
		cur = 1'b0;
		cl = 1'b0;
		found = 1'b0;
		el3 = 1'b0;
		el4 = 1'b0;
		s_next = s_reg;
		s_next.rsv_ok = 1'b0;
		s_next.rsv_refused = 1'b0;
		s_next.to_abort = 1'b0;

		// Register writes; clear is write-only and acts for one cycle
		if (i_bus.wr) begin
			if (i_bus.addr == `CEC_OFS_IEN) begin
				s_next.en = i_bus.wdata & `CEC_IRQ_MASK;
			end else if (i_bus.addr == `CEC_OFS_ICLR) begin
				clr = i_bus.wdata & `CEC_IRQ_MASK;
			end else if (i_bus.addr == `CEC_OFS_MCTL) begin
				s_next.snoop = i_bus.wdata[`CEC_MC_SNOOP];
				s_next.prio = i_bus.wdata[31:0];
				if (i_bus.wdata[`CEC_MC_SRST]) begin
					s_next.srst = 1'b1;
					s_next.srst_cnt = `CEC_SRST_CYC;
				end
			end
		end

		// Register reads; unmapped and write-only offsets read zero
		s_next.rdata = '0;
		if (i_bus.rd) begin
			if (i_bus.addr == `CEC_OFS_IEN) begin
				s_next.rdata = s_reg.en;
			end else if (i_bus.addr == `CEC_OFS_IST) begin
				s_next.rdata = s_reg.st;
			end else if (i_bus.addr == `CEC_OFS_UASG) begin
				s_next.rdata = {32'h0000_0000, s_reg.asg};
			end else if (i_bus.addr == `CEC_OFS_MCTL) begin
				s_next.rdata = {30'h0000_0000, s_reg.snoop, s_reg.srst,
					s_reg.prio};
			end
		end

		// Slave watchdog: a channel or unit that never answers would hang
		// the internal bus, so the access is closed as failed
		if (i_slv.busy && !i_slv.ack) begin
			if (s_reg.to_cnt == `CEC_TIMEOUT_CYC - 5'd1) begin
				s_next.to_cnt = '0;
				s_next.to_abort = 1'b1;
				cause[`CEC_BIT_ITO] = 1'b1;
			end else begin
				s_next.to_cnt = s_reg.to_cnt + 5'd1;
			end
		end else begin
			s_next.to_cnt = '0;
		end

		// Interrupt causes from counters, channels and units
		cause[`CEC_BIT_FETCH_WRAP] = i_wrap.fetch_enqueue_wrap;
		cause[`CEC_BIT_DESC_WRAP] = i_wrap.descriptor_finished_wrap;
		cause[`CEC_BIT_DIN_WRAP] = i_wrap.data_in_wrap;
		cause[`CEC_BIT_DOUT_WRAP] = i_wrap.data_out_wrap;
		for (int c = 0; c < 4; c++) begin
			cause[`CEC_BIT_CH_DN_BASE + 2 * c + 1] = i_ch_err[c];
		end
		// Unit done arrives already qualified by the unit itself
		for (int u = 0; u < 8; u++) begin
			pos = 5'(`CEC_UNIT_DN_POS >> (5 * u));
			cause[pos] = i_unit_done[u];
			cause[pos + 5'd1] = i_unit_err[u];
		end

		// Channel done queues: extra done events wait in a counter and
		// re-raise the bit one cycle after each clear
		for (int c = 0; c < 4; c++) begin
			cl = clr[`CEC_BIT_CH_DN_BASE + 2 * c];
			cur = s_reg.st[`CEC_BIT_CH_DN_BASE + 2 * c] & ~cl;
			cnt = s_reg.dq[c];
			if (!cur && !cl && cnt != 4'h0) begin
				cur = 1'b1;
				cnt = cnt - 4'h1;
			end
			if (i_ch_done[c]) begin
				if (!cur && !cl) begin
					cur = 1'b1;
				end else if (cnt != `CEC_QUEUE_MAX) begin
					cnt = cnt + 4'h1;
				end else begin
					cause[`CEC_BIT_OVF_BASE + c] = 1'b1;
				end
			end
			if (!s_reg.en[`CEC_BIT_CH_DN_BASE + 2 * c]) begin
				cur = 1'b0;
				cnt = 4'h0;
			end
			dn_st[`CEC_BIT_CH_DN_BASE + 2 * c] = cur;
			s_next.dq[c] = cnt;
		end

		// Other bits: a cause during its clear is held and sets the bit
		// one cycle later, so the clear shows yet no event is lost
		gen = ((s_reg.st | cause) & ~clr) | s_reg.pend;
		s_next.pend = clr & cause & s_reg.en & ~`CEC_DONE_MASK;
		s_next.st = ((gen & ~`CEC_DONE_MASK) | dn_st) & s_reg.en
			& `CEC_IRQ_MASK;

		// Unit assignment table
		for (int u = 0; u < 8; u++) begin
			if (i_unit_unavail[u] && s_reg.asg[u] == `CEC_ASG_FREE) begin
				s_next.asg[u] = `CEC_ASG_UNAVAIL;
			end else if (!i_unit_unavail[u]
				&& s_reg.asg[u] == `CEC_ASG_UNAVAIL) begin
				s_next.asg[u] = `CEC_ASG_FREE;
			end
		end
		if (i_rsv.valid) begin
			if (i_rsv.release_unit) begin
				if (s_reg.asg[i_rsv.unit] == {2'b00, i_rsv.chan} + 4'h1) begin
					s_next.asg[i_rsv.unit] = `CEC_ASG_FREE;
				end
			end else if (s_reg.asg[i_rsv.unit] == `CEC_ASG_FREE
				&& !i_unit_unavail[i_rsv.unit]) begin
				s_next.asg[i_rsv.unit] = {2'b00, i_rsv.chan} + 4'h1;
				s_next.rsv_ok = 1'b1;
			end else begin
				s_next.rsv_refused = 1'b1;
			end
		end

		// Arbiters: index 0 for the shared bus, 1 for the units
		for (int k = 0; k < 2; k++) begin
			c3 = (k == 0) ? s_reg.prio[15:8] : s_reg.prio[31:24];
			c4 = (k == 0) ? s_reg.prio[7:0] : s_reg.prio[23:16];
			lim3 = (c3 == 8'h00) ? `CEC_PRIO_ZERO_AS : {1'b0, c3};
			lim4 = (c4 == 8'h00) ? `CEC_PRIO_ZERO_AS : {1'b0, c4};
			el3 = s_reg.deny[k][0] >= lim3;
			el4 = s_reg.deny[k][1] >= lim4;
			g = 4'h0;
			found = 1'b0;
			if (c3 == 8'h00 && c4 == 8'h00) begin
				for (int j = 1; j < 5; j++) begin
					idx = s_reg.last[k] + j[1:0];
					if (!found && i_arb_req[k][idx]) begin
						g[idx] = 1'b1;
						found = 1'b1;
					end
				end
			end else if (i_arb_req[k][0]) begin
				g = 4'h1;
			end else if (el3 && i_arb_req[k][2]) begin
				g = 4'h4;
			end else if (el4 && i_arb_req[k][3]) begin
				g = 4'h8;
			end else if (i_arb_req[k][1]) begin
				g = 4'h2;
			end else if (i_arb_req[k][2]) begin
				g = 4'h4;
			end else if (i_arb_req[k][3]) begin
				g = 4'h8;
			end
			s_next.grant[k] = g;
			// Remember the winner and count losses of channels 3 and 4
			if (g != 4'h0) begin
				s_next.last[k] = {g[3] | g[2], g[3] | g[1]};
				if (g[2]) begin
					s_next.deny[k][0] = '0;
				end else if (i_arb_req[k][2] && !el3) begin
					s_next.deny[k][0] = s_reg.deny[k][0] + 9'd1;
				end
				if (g[3]) begin
					s_next.deny[k][1] = '0;
				end else if (i_arb_req[k][3] && !el4) begin
					s_next.deny[k][1] = s_reg.deny[k][1] + 9'd1;
				end
			end
		end

		// Software reset: engine state is cleared while it runs; the
		// enable and master control settings are kept
		if (s_reg.srst) begin
			if (s_reg.srst_cnt == 4'h0) begin
				s_next.srst = 1'b0;
			end else begin
				s_next.srst_cnt = s_reg.srst_cnt - 4'h1;
			end
			s_next.st = '0;
			s_next.pend = '0;
			s_next.dq = '0;
			s_next.asg = '0;
			s_next.deny = '0;
			s_next.last = '0;
			s_next.grant = '0;
			s_next.to_cnt = '0;
			s_next.rsv_ok = 1'b0;
			s_next.rsv_refused = 1'b0;
		end

		s_next.irq = |s_next.st;
	end

	// State register; everything resets to zero
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			s_reg <= '0;
			s_reg.en <= `CEC_IEN_RST;
			s_reg.prio <= `CEC_MCTL_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	// Outputs straight from the state register
	assign o_rdata = s_reg.rdata;
	assign o_rsv_ok = s_reg.rsv_ok;
	assign o_rsv_refused = s_reg.rsv_refused;
	assign o_slv_abort = s_reg.to_abort;
	assign o_arb_grant = s_reg.grant;
	assign o_snoop_inhibit = s_reg.snoop;
	assign o_soft_reset = s_reg.srst;
	assign o_irq = s_reg.irq;

endmodule

// ### bench/cec_ctrl_asserts.sv
// Purpose: Port-level checks of the controller registers.
// Assumes: Bound into every cec_ctrl instance.
// Notes: A small counter mirrors the slave wait.
`timescale 1ns/10ps
`include "cec_consts.svh"
module cec_ctrl_asserts
	import cec_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rstn,
	input wire cec_bus_t i_bus,
	input wire logic [63:0] o_rdata,
	input wire cec_rsv_t i_rsv,
	input wire logic o_rsv_ok,
	input wire logic o_rsv_refused,
	input wire cec_slv_t i_slv,
	input wire logic o_slv_abort,
	input wire logic [1:0][3:0] i_arb_req,
	input wire logic [1:0][3:0] o_arb_grant,
	input wire logic o_soft_reset
);
	logic [4:0] wait_reg;
	default clocking @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rstn);
	// Unanswered slave edges; restarts after each abort
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn)
			wait_reg <= '0;
		else if (i_slv.busy && !i_slv.ack)
			wait_reg <= (wait_reg == 5'd16) ? 5'd1 : wait_reg + 5'd1;
		else
			wait_reg <= '0;
	end
	a_rd_idle: assert property (!$past(i_bus.rd) |-> o_rdata == 64'h0)
	else $error("read data outside its slot");
	a_clear_reads_zero: assert property (i_bus.rd &&
		i_bus.addr == `CEC_OFS_ICLR |=> o_rdata == 64'h0)
	else $error("clear register read not zero");
	a_timeout_abort: assert property (wait_reg == 5'd16 |-> o_slv_abort)
	else $error("no abort after silent slave");
	a_abort_cause: assert property (o_slv_abort |-> wait_reg == 5'd16)
	else $error("abort without timeout");
	a_rsv_answer: assert property (i_rsv.valid && !i_rsv.release_unit
		|=> o_rsv_ok != o_rsv_refused)
	else $error("reservation not answered once");
	a_rsv_quiet: assert property (!i_rsv.valid |=>
		!o_rsv_ok && !o_rsv_refused)
	else $error("reservation answer without request");
	a_bus_grant: assert property (|i_arb_req[0] && !o_soft_reset |=>
		$onehot(o_arb_grant[0]) && !(o_arb_grant[0] & ~$past(i_arb_req[0])))
	else $error("bad bus grant");
	a_unit_grant: assert property (|i_arb_req[1] && !o_soft_reset |=>
		$onehot(o_arb_grant[1]) && !(o_arb_grant[1] & ~$past(i_arb_req[1])))
	else $error("bad unit grant");
	a_no_req_grant: assert property (i_arb_req == 8'h0 |=>
		o_arb_grant == 8'h0)
	else $error("grant without request");
	a_srst_len: assert property ($rose(o_soft_reset) |=>
		o_soft_reset [*8] ##1 !o_soft_reset)
	else $error("soft reset length wrong");
endmodule
bind cec_ctrl cec_ctrl_asserts u_asserts (.i_core_clk(i_core_clk),
	.i_rstn(i_rstn), .i_bus(i_bus), .o_rdata(o_rdata), .i_rsv(i_rsv),
	.o_rsv_ok(o_rsv_ok), .o_rsv_refused(o_rsv_refused), .i_slv(i_slv),
	.o_slv_abort(o_slv_abort), .i_arb_req(i_arb_req),
	.o_arb_grant(o_arb_grant), .o_soft_reset(o_soft_reset));

// ### bench/cec_slv_model.sv
// Purpose: Channel or unit slave answering internal accesses.
// Assumes: One access at a time, started by i_go.
// Notes: i_hang keeps it silent until the controller aborts.
`timescale 1ns/10ps
module cec_slv_model
	import cec_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_go,
	input wire logic i_hang,
	input wire logic i_abort,
	output cec_slv_t o_slv
);
	logic [1:0] n;
	// Answer a few cycles after start; a hung slave waits for abort
	always @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_slv <= '0;
			n <= '0;
		end else if (i_go) begin
			o_slv <= 2'b10;
			n <= '0;
		end else if (o_slv.busy) begin
			n <= n + 2'd1;
			o_slv.ack <= !i_hang && n == 2'd2;
			if (o_slv.ack || i_abort)
				o_slv.busy <= 1'b0;
		end
	end
endmodule

// ### bench/cec_ctrl_tb_top.sv
// Purpose: Self-checking bench for the controller registers.
// Assumes: 10 MHz clock, reads scored by a queue monitor.
// Notes: Unit 7 is held absent throughout.
`timescale 1ns/10ps
`include "cec_consts.svh"
module cec_ctrl_tb_top
	import cec_pkg::*;
;
	localparam logic [17:0] AEN = `CEC_OFS_IEN, AST = `CEC_OFS_IST;
	localparam logic [17:0] ACL = `CEC_OFS_ICLR, AAS = `CEC_OFS_UASG;
	localparam logic [17:0] AMC = `CEC_OFS_MCTL;
	logic clk = 0, rstn = 0, go = 0, hang = 0, pend = 0;
	cec_bus_t bus = '0;
	cec_rsv_t rsv = '0;
	cec_slv_t slv;
	logic [27:0] evt = '0;
	logic [7:0] arb = '0;
	logic [63:0] rdata, q[$];
	logic [1:0][3:0] gnt;
	logic ok, rf, abt, srst, snp, irq;
	int errors = 0, n_tests = 0, dn[8] = '{26, 24, 20, 16, 12, 8, 4, 0};
	logic [31:0] lf = 32'hd251;
	cec_ctrl dut (.i_core_clk(clk), .i_rstn(rstn), .i_bus(bus),
		.o_rdata(rdata), .i_wrap(cec_wrap_t'(evt[3:0])),
		.i_ch_done(evt[7:4]), .i_ch_err(evt[11:8]),
		.i_unit_done(evt[19:12]), .i_unit_err(evt[27:20]),
		.i_unit_unavail(8'h80), .i_rsv(rsv), .o_rsv_ok(ok),
		.o_rsv_refused(rf), .i_slv(slv), .o_slv_abort(abt),
		.i_arb_req(arb), .o_arb_grant(gnt), .o_snoop_inhibit(snp),
		.o_soft_reset(srst), .o_irq(irq));
	cec_slv_model slave (.i_clk(clk), .i_rstn(rstn), .i_go(go),
		.i_hang(hang), .i_abort(abt), .o_slv(slv));
	function logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task end_of_test;
		if (errors == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input logic [63:0] g, input logic [63:0] e);
		n_tests++;
		if (g !== e) begin
			errors++;
			$display("wrong value at %0t: %h expected %h", $time, g, e);
		end
	endtask
	// Bus cycles leave one idle edge so no strobe is driven twice at once
	task wr(input logic [17:0] a, input logic [63:0] d);
		@(posedge clk);
		bus <= '{1'b1, 1'b0, a, d};
		@(posedge clk);
		bus <= '0;
	endtask
	task rd(input logic [17:0] a, input logic [63:0] e);
		@(posedge clk);
		bus <= '{1'b0, 1'b1, a, 64'h0};
		q.push_back(e);
		@(posedge clk);
		bus <= '0;
	endtask
	task pulse(input logic [27:0] v);
		@(posedge clk);
		evt <= v;
		@(posedge clk);
		evt <= '0;
	endtask
	task rsvt(input logic [5:0] v, input logic [1:0] e);
		@(posedge clk);
		rsv <= {1'b1, v};
		@(posedge clk);
		rsv <= '0;
		#1 chk({ok, rf}, e);
	endtask
	task slvt(input logic h);
		logic t;
		@(posedge clk);
		go <= 1'b1;
		hang <= h;
		@(posedge clk);
		go <= 1'b0;
		t = 0;
		repeat (24) @(posedge clk) t |= abt;
		chk(t, h);
	endtask
	task arbt(input logic [7:0] r, input logic [31:0] e, input int n);
		@(posedge clk);
		arb <= r;
		for (int k = 0; k < n; k++) begin
			@(posedge clk);
			#1 chk(gnt, e[31-8*k -: 8]);
		end
		arb <= '0;
	endtask
	initial forever #50 clk = ~clk;
	// Read data stand in the cycle after the strobe; oldest note first
	always @(negedge clk) begin
		if (pend)
			chk(rdata, q.pop_front());
		pend = bus.rd;
	end
	// Hang guard, well beyond the few hundred cycles needed
	initial begin
		#3000000;
		errors++;
		end_of_test();
	end
	initial begin
		logic [63:0] e;
		logic [27:0] v;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		rd(AEN, 64'h0);
		rd(AST, 64'h0);
		rd(ACL, 64'h0);
		rd(18'h31000, 64'h0);
		rd(AAS, 64'hf000_0000);
		// Round robin starts behind channel one after reset
		arbt(8'hff, 32'h2244_8811, 4);
		lf = lfsr(lf);
		wr(AEN, {lf, ~lf});
		rd(AEN, {lf, ~lf} & `CEC_IRQ_MASK);
		wr(AEN, 64'h0);
		pulse(28'hfff_ffff);
		rd(AST, 64'h0);
		wr(AEN, 64'h0031_0fff_0000_0000);
		rd(AEN, 64'h0031_0fff_0000_0000);
		wr(AEN, `CEC_IRQ_MASK);
		// Each source alone: counter wraps, channels, units
		for (int i = 0; i < 16; i++) begin
			v = i < 4 ? 28'h1 << i : i < 8 ? 28'h11 << i : 28'h101 << (i + 4);
			e = i < 4 ? 64'h1 << (52 + i) : i < 8 ? 64'h3 << (24 + 2 * i)
				: 64'h3 << dn[i - 8];
			pulse(v);
			rd(AST, e);
			chk(irq, 1'b1);
			wr(ACL, e);
			rd(AST, 64'h0);
			chk(irq, 1'b0);
		end
		// Seventeen done events: fifteen queue, the last overflows
		repeat (17) pulse(28'h10);
		for (int k = 0; k < 17; k++) begin
			rd(AST, k < 16 ? 64'h101_0000_0000 : 64'h0);
			if (k < 16)
				wr(ACL, k == 15 ? 64'h101_0000_0000 : 64'h1_0000_0000);
		end
		slvt(1'b1);
		rd(AST, 64'h1_0000_0000_0000);
		wr(ACL, 64'h1_0000_0000_0000);
		slvt(1'b0);
		rsvt({1'b0, 2'd2, 3'd3}, 2'b10);
		rsvt({1'b0, 2'd0, 3'd3}, 2'b01);
		rsvt({1'b0, 2'd1, 3'd7}, 2'b01);
		rsvt({1'b0, 2'd0, 3'd5}, 2'b10);
		rsvt({1'b1, 2'd0, 3'd3}, 2'b00);
		rd(AAS, 64'hf010_3000);
		// Soft reset wipes status and table but keeps master control
		pulse(28'h10);
		wr(AMC, 64'h3_0000_0100);
		repeat (12) @(posedge clk);
		rd(AMC, 64'h2_0000_0100);
		chk(snp, 1'b1);
		rd(AST, 64'h0);
		rd(AAS, 64'hf000_0000);
		// Channel three promoted above two after one loss
		arbt(8'h06, 32'h0204_0000, 2);
		end_of_test();
	end
endmodule
